// ---- verilog/mac_mode_pkg.sv ----
// constants for the duplex, speed and loopback control slice
package mac_mode_pkg;
  localparam logic [11:0] CTRL_OFF  = 12'h000;
  localparam logic [11:0] STAT_OFF  = 12'h004;
  localparam logic [11:0] PROT_OFF  = 12'h008;
  localparam int          RECEIVER_ENABLE_BIT  = 0;
  localparam int          TRANSMITTER_ENABLE_BIT  = 1;
  localparam int          SPD_LO    = 2;
  localparam int          DPX_BIT   = 4;
  localparam int          LOOP_BIT  = 10;
  localparam int          ASD_BIT   = 11;
  localparam int          ADD_BIT   = 12;
  localparam int          POL_BIT   = 13;
  localparam logic        POL_RST   = 1'b1;
  localparam logic        LOOP_RST  = 1'b0;
  localparam logic        DPX_RST   = 1'b0;
  localparam logic [1:0]  SPD_RST   = 2'h0;
  localparam logic [1:0]  SPD_10    = 2'h0;
  localparam logic [1:0]  SPD_100   = 2'h1;
  localparam logic [1:0]  SPD_1000  = 2'h2;
  localparam int          CLK_NS    = 10;
  localparam int          WIN_NS    = 10000;
  localparam int          WIN_CYC   = WIN_NS / CLK_NS;
  localparam int          EDGE_MIN  = 5;
  localparam int          EDGE_100  = 100;
  localparam int          EDGE_1000 = 600;
endpackage

// ---- verilog/level_sync.sv ----
// two flip-flop synchroniser for pin levels
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_r;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ---- verilog/speed_detect.sv ----
// classifies the rx clock by edge count over a window
`timescale 1ns/1ps
`default_nettype none
module speed_detect
  import mac_mode_pkg::*;
#(
  parameter int WIN = WIN_CYC
) (
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  input  wire logic       rx_clk_s,
  output logic      [1:0] det_speed,
  output logic            det_valid
);
  logic [15:0] win_r;
  logic [15:0] edges_r;
  logic        prev_r;
  logic        rise;
  logic        win_end;
  logic [1:0]  class_spd;

  assign rise    = rx_clk_s & ~prev_r;
  assign win_end = (win_r == 16'(WIN - 1));
  assign class_spd = (edges_r >= 16'(EDGE_1000)) ? SPD_1000 :
                     (edges_r >= 16'(EDGE_100))  ? SPD_100 : SPD_10;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      win_r     <= '0;
      edges_r   <= '0;
      prev_r    <= 1'b0;
      det_speed <= SPD_RST;
      det_valid <= 1'b0;
    end else begin
      prev_r  <= rx_clk_s;
      win_r   <= win_end ? '0 : win_r + 16'h0001;
      edges_r <= win_end ? '0 : edges_r + {15'h0000, rise};
      if (win_end && edges_r >= 16'(EDGE_MIN)) begin
        det_speed <= class_spd;
        det_valid <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- verilog/mac_mode_ctrl.sv ----
// duplex, speed and loopback control with apb registers
`timescale 1ns/1ps
`default_nettype none
module mac_mode_ctrl
  import mac_mode_pkg::*;
#(
  parameter logic ADD_RST = 1'b0,
  parameter logic ASD_RST = 1'b0,
  parameter int   WIN     = WIN_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        soft_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        phy_full_duplex_led,
  input  wire logic        rx_clk,
  input  wire logic [7:0]  phy_rxd,
  input  wire logic        phy_rx_dv,
  input  wire logic        phy_rx_er,
  input  wire logic [7:0]  mac_txd,
  input  wire logic        mac_tx_en,
  input  wire logic        mac_tx_er,
  output logic      [7:0]  gmii_txd,
  output logic             gmii_tx_en,
  output logic             gmii_tx_er,
  output logic      [7:0]  mac_rxd,
  output logic             mac_rx_dv,
  output logic             mac_rx_er,
  output logic             full_duplex,
  output logic      [1:0]  link_speed,
  output logic             receiver_enable,
  output logic             transmitter_enable
);
  logic       pol_r;
  logic       add_r;
  logic       asd_r;
  logic       loop_r;
  logic       dpx_r;
  logic [1:0] spd_r;
  logic       prot_r;
  logic       led_s;
  logic       rxclk_s;
  logic [9:0] phy_s;
  logic [1:0] det_speed;
  logic       det_valid;

  level_sync #(.W(1)) u_led_sync (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .async_in (phy_full_duplex_led),
    .sync_out (led_s)
  );

  level_sync #(.W(11)) u_rx_sync (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .async_in ({rx_clk, phy_rxd, phy_rx_dv, phy_rx_er}),
    .sync_out ({rxclk_s, phy_s})
  );

  speed_detect #(.WIN(WIN)) u_speed (
    .sys_clk   (sys_clk),
    .resetn    (resetn),
    .rx_clk_s  (rxclk_s),
    .det_speed (det_speed),
    .det_valid (det_valid)
  );

  // apb decode
  wire setup   = psel & ~penable;
  wire access  = psel & penable;
  wire ans     = access & ~pready;
  wire wr_take = access & pready & pwrite & ~pslverr;
  wire hit_c   = (paddr == CTRL_OFF);
  wire hit_s   = (paddr == STAT_OFF);
  wire hit_p   = (paddr == PROT_OFF);
  wire mapped  = hit_c | hit_s | hit_p;
  wire wr_c    = wr_take & hit_c;
  wire wr_p    = wr_take & hit_p;

  wire det_dpx = pol_r ? led_s : ~led_s;

  wire dpx_eff = add_r ? det_dpx : dpx_r;

  wire [1:0] spd_eff = asd_r ? det_speed : spd_r;

  wire [31:0] ctrl_word = {18'h00000, pol_r, add_r, asd_r, loop_r,
                           5'h00, dpx_r, spd_r, transmitter_enable,
                           receiver_enable};
  wire [31:0] stat_word = {27'h0000000, led_s, det_valid, link_speed,
                           full_duplex};
  wire [31:0] rd_word   = hit_c ? ctrl_word :
                          hit_s ? stat_word :
                          hit_p ? {31'h00000000, prot_r} : 32'h00000000;

  // one wait state per transfer
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= ans;
      pslverr <= ans & ~mapped;
      if (ans) begin
        prdata <= pwrite ? 32'h00000000 : rd_word;
      end
    end
  end

  wire keep = soft_rst & prot_r;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pol_r <= POL_RST;
      add_r <= ADD_RST;
      asd_r <= ASD_RST;
    end else if (soft_rst && !keep) begin
      pol_r <= POL_RST;
      add_r <= ADD_RST;
      asd_r <= ASD_RST;
    end else if (wr_c && !soft_rst) begin
      pol_r <= pwdata[POL_BIT];
      add_r <= pwdata[ADD_BIT];
      asd_r <= pwdata[ASD_BIT];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      prot_r <= 1'b0;
    end else if (wr_p) begin
      prot_r <= pwdata[0];
    end
  end

  // loopback bit, cleared by any reset
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      loop_r             <= LOOP_RST;
      receiver_enable    <= 1'b0;
      transmitter_enable <= 1'b0;
    end else if (soft_rst) begin
      loop_r             <= LOOP_RST;
      receiver_enable    <= 1'b0;
      transmitter_enable <= 1'b0;
    end else if (wr_c) begin
      loop_r             <= pwdata[LOOP_BIT];
      receiver_enable    <= pwdata[RECEIVER_ENABLE_BIT];
      transmitter_enable <= pwdata[TRANSMITTER_ENABLE_BIT];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      dpx_r <= DPX_RST;
    end else if (add_r) begin
      dpx_r <= det_dpx;
    end else if (soft_rst) begin
      dpx_r <= DPX_RST;
    end else if (wr_c) begin
      dpx_r <= pwdata[DPX_BIT];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      spd_r <= SPD_RST;
    end else if (asd_r) begin
      spd_r <= det_speed;
    end else if (soft_rst) begin
      spd_r <= SPD_RST;
    end else if (wr_c) begin
      spd_r <= pwdata[SPD_LO +: 2];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      full_duplex <= DPX_RST;
      link_speed  <= SPD_RST;
    end else begin
      full_duplex <= dpx_eff;
      link_speed  <= spd_eff;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      gmii_txd   <= 8'h00;
      gmii_tx_en <= 1'b0;
      gmii_tx_er <= 1'b0;
      mac_rxd    <= 8'h00;
      mac_rx_dv  <= 1'b0;
      mac_rx_er  <= 1'b0;
    end else if (loop_r) begin
      gmii_txd   <= 8'h00;
      gmii_tx_en <= 1'b0;
      gmii_tx_er <= 1'b0;
      mac_rxd    <= mac_txd;
      mac_rx_dv  <= mac_tx_en;
      mac_rx_er  <= mac_tx_er;
    end else begin
      gmii_txd   <= mac_txd;
      gmii_tx_en <= mac_tx_en;
      gmii_tx_er <= mac_tx_er;
      mac_rxd    <= phy_s[9:2];
      mac_rx_dv  <= phy_s[1];
      mac_rx_er  <= phy_s[0];
    end
  end

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  chk_pol_high_full: assert property (
    add_r && pol_r && led_s && $stable(add_r) |=> full_duplex)
    else $error("high indicator with polarity 1 not full");

  chk_pol_low_full: assert property (
    add_r && !pol_r && !led_s && $stable(add_r) |=> full_duplex)
    else $error("low indicator with polarity 0 not full");

  chk_auto_ignore_sw: assert property (
    add_r && $past(add_r) && wr_c && pwdata[DPX_BIT] != det_dpx
      |=> dpx_r == $past(det_dpx))
    else $error("software duplex write won in auto mode");

  chk_dpx_readback: assert property (
    add_r |=> dpx_r == $past(det_dpx) && full_duplex == dpx_r)
    else $error("detected duplex not reported");

  chk_manual_dpx: assert property (
    !add_r ##1 !add_r |-> full_duplex == $past(dpx_r))
    else $error("manual duplex not followed");

  chk_auto_speed: assert property (
    asd_r && $past(asd_r) |-> link_speed == $past(det_speed))
    else $error("auto speed not from detector");

  chk_speed_readback: assert property (
    asd_r |=> spd_r == $past(det_speed))
    else $error("detected speed not reported");

  chk_manual_speed: assert property (
    !asd_r |=> link_speed == $past(spd_r))
    else $error("manual speed not followed");

  chk_loop_no_phy: assert property (
    loop_r |=> !gmii_tx_en && !gmii_tx_er && gmii_txd == 8'h00)
    else $error("phy driven during loopback");

  chk_loop_return: assert property (
    loop_r && mac_tx_en |=> mac_rx_dv && mac_rxd == $past(mac_txd))
    else $error("tx frame not returned in loopback");

  chk_soft_rst_loop: assert property (
    soft_rst |=> !loop_r)
    else $error("loopback not cleared by soft reset");

  chk_protect_keep: assert property (
    soft_rst && prot_r |=> pol_r == $past(pol_r) && add_r == $past(add_r)
      && asd_r == $past(asd_r))
    else $error("protected bits lost");

  chk_sync_delay: assert property (
    (add_r && $stable(pol_r) && $stable(phy_full_duplex_led)) [*5]
      |-> full_duplex == (pol_r ? phy_full_duplex_led : !phy_full_duplex_led))
    else $error("duplex not from synchronised indicator");

  chk_apb_wait: assert property (
    setup ##1 access |-> !pready ##1 pready)
    else $error("apb answer not after one wait");

  chk_tx_pass: assert property (
    !loop_r |=> gmii_tx_en == $past(mac_tx_en) && gmii_txd == $past(mac_txd)
      && gmii_tx_er == $past(mac_tx_er))
    else $error("tx path not passed to phy");

  chk_rx_pass: assert property (
    !loop_r |=> mac_rxd == $past(phy_s[9:2]) && mac_rx_dv == $past(phy_s[1])
      && mac_rx_er == $past(phy_s[0]))
    else $error("rx path not taken from phy");

  chk_loop_err: assert property (
    loop_r |=> mac_rx_er == $past(mac_tx_er))
    else $error("tx error not returned in loopback");

  chk_loop_write: assert property (
    wr_c && !soft_rst |=> loop_r == $past(pwdata[LOOP_BIT]))
    else $error("loopback bit write lost");

  chk_pol_write: assert property (
    wr_c && !soft_rst |=> pol_r == $past(pwdata[POL_BIT]))
    else $error("polarity bit write lost");

  chk_unprot_reset: assert property (
    soft_rst && !prot_r |=> pol_r == POL_RST && add_r == ADD_RST
      && asd_r == ASD_RST)
    else $error("unprotected bits kept over soft reset");

  chk_dpx_write: assert property (
    !add_r && wr_c && !soft_rst |=> dpx_r == $past(pwdata[DPX_BIT]))
    else $error("manual duplex write lost");

  chk_spd_write: assert property (
    !asd_r && wr_c && !soft_rst |=> spd_r == $past(pwdata[SPD_LO +: 2]))
    else $error("manual speed write lost");

  chk_apb_err: assert property (
    access && !pready && !mapped |=> pready && pslverr)
    else $error("unmapped access without error");

  chk_ready_pulse: assert property (
    pready |=> !pready)
    else $error("ready held over one cycle");

  chk_led_sync: assert property (
    $past(resetn, 2) |-> led_s == $past(phy_full_duplex_led, 2))
    else $error("indicator not two flops late");

  chk_soft_enables: assert property (
    soft_rst |=> !receiver_enable && !transmitter_enable)
    else $error("enables not cleared by soft reset");

  cov_auto_full: cover property (add_r && full_duplex ##1 !full_duplex);
  cov_loop_frame: cover property (loop_r && mac_tx_en ##1 mac_rx_dv);
  cov_speed_1000: cover property (asd_r && link_speed == SPD_1000);
  cov_unmapped: cover property (pready && pslverr);
  cov_soft_keep: cover property (soft_rst && prot_r);

endmodule
`default_nettype wire

// ---- verification/phy_model.sv ----
// phy model: free running rx clock, echoes tx bytes back on rx pins
`timescale 1ns/1ps
`default_nettype none
module phy_model (
  input  wire logic [8:0] half_ns,
  input  wire logic [7:0] gmii_txd,
  input  wire logic       gmii_tx_en,
  output logic            rx_clk,
  output logic      [7:0] phy_rxd,
  output logic            phy_rx_dv,
  output logic            phy_rx_er
);
  // idle data toggles so stale bytes never look valid
  initial begin
    rx_clk = 1'b0;
    phy_rxd = 8'h00;
    phy_rx_dv = 1'b0;
    forever begin
      #(half_ns);
      rx_clk = ~rx_clk;
      if (rx_clk) begin
        phy_rx_dv = gmii_tx_en;
        phy_rxd = gmii_tx_en ? gmii_txd : ~phy_rxd;
      end
    end
  end
  assign phy_rx_er = 1'b0;
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
// self-checking bench for the duplex, speed and loopback slice
`timescale 1ns/1ps
`default_nettype none
`define CK(a, e) begin compares++; if ((a) !== (e)) begin n_errors++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, (a), (e)); end end
module testbench;
  import mac_mode_pkg::*;
  logic sys_clk, resetn, soft_rst, psel, penable, pwrite, pready, pslverr, led;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic rx_clk, rx_dv, rx_er, tx_en, tx_er, g_en, g_er, m_dv, m_er, fd, ren, ten, er;
  logic [7:0] rxd, txd, g_d, m_d;
  logic [1:0] spd;
  logic [8:0] half_ns;
  int n_errors, compares, i;
  logic [35:0] rows [7] = '{{32'h2000, 1'b1, 1'b0, 2'h0}, {32'h2014, 1'b0, 1'b1, 2'h1},
    {32'h2008, 1'b1, 1'b0, 2'h2}, {32'h3000, 1'b1, 1'b1, 2'h0}, {32'h3010, 1'b0, 1'b0, 2'h0},
    {32'h1000, 1'b0, 1'b1, 2'h0}, {32'h1010, 1'b1, 1'b0, 2'h0}};
  mac_mode_ctrl #(.WIN(1000)) mac_mode_ctrl_inst (.sys_clk(sys_clk), .resetn(resetn),
    .soft_rst(soft_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .phy_full_duplex_led(led), .rx_clk(rx_clk), .phy_rxd(rxd), .phy_rx_dv(rx_dv),
    .phy_rx_er(rx_er), .mac_txd(txd), .mac_tx_en(tx_en), .mac_tx_er(tx_er),
    .gmii_txd(g_d), .gmii_tx_en(g_en), .gmii_tx_er(g_er), .mac_rxd(m_d), .mac_rx_dv(m_dv),
    .mac_rx_er(m_er), .full_duplex(fd), .link_speed(spd), .receiver_enable(ren),
    .transmitter_enable(ten));
  phy_model phy_model_inst (.half_ns(half_ns), .gmii_txd(g_d), .gmii_tx_en(g_en),
    .rx_clk(rx_clk), .phy_rxd(rxd), .phy_rx_dv(rx_dv), .phy_rx_er(rx_er));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // mode bits are written whatever the enables; the bench sets the enables only near the end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic send(input logic [7:0] d);
    tx_en <= 1'b1;
    txd <= d;
    @(posedge sys_clk);
    tx_en <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic pulse_soft;
    soft_rst <= 1'b1;
    @(posedge sys_clk);
    soft_rst <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic complete_run;
    $display("errors=%0d compares=%0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #300us;
    n_errors++;
    complete_run();
  end
  initial begin
    {resetn, soft_rst, psel, penable, pwrite, tx_en, tx_er, led} = 8'h00;
    {paddr, pwdata, txd} = '0;
    half_ns = 9'd200;
    n_errors = 0;
    compares = 0;
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    apb(1'b0, CTRL_OFF, 32'h0);
    `CK(rd, 32'h0000_2000)
    `CK({fd, spd}, 3'h0)
    for (i = 0; i < 7; i++) begin
      apb(1'b1, CTRL_OFF, rows[i][35:4]);
      led <= rows[i][3];
      repeat (6) @(posedge sys_clk);
      apb(1'b0, CTRL_OFF, 32'h0);
      `CK(fd, rows[i][2])
      `CK(spd, rows[i][1:0])
      `CK(rd[4], rows[i][2])
    end
    // auto speed with software field set to 1000
    apb(1'b1, CTRL_OFF, 32'h2808);
    half_ns = 9'd40;
    for (i = 0; i < 3000 && spd !== SPD_100; i++) @(posedge sys_clk);
    `CK(spd, SPD_100)
    apb(1'b0, CTRL_OFF, 32'h0);
    `CK(rd[3:2], SPD_100)
    half_ns = 9'd200;
    for (i = 0; i < 3000 && spd !== SPD_10; i++) @(posedge sys_clk);
    `CK(spd, SPD_10)
    // loopback, here run with full duplex selected
    apb(1'b1, CTRL_OFF, 32'h2410);
    send(8'hA5);
    `CK({m_dv, m_d, g_en}, 10'h34A)
    apb(1'b0, CTRL_OFF, 32'h0);
    `CK(rd[10], 1'b1)
    apb(1'b1, CTRL_OFF, 32'h2010);
    send(8'h3C);
    `CK({g_en, g_d}, 9'h13C)
    apb(1'b1, PROT_OFF, 32'h1);
    apb(1'b1, CTRL_OFF, 32'h1400);
    pulse_soft();
    apb(1'b0, CTRL_OFF, 32'h0);
    `CK(rd & 32'h3400, 32'h0000_1000)
    apb(1'b1, PROT_OFF, 32'h0);
    apb(1'b1, CTRL_OFF, 32'h1400);
    pulse_soft();
    apb(1'b0, CTRL_OFF, 32'h0);
    `CK(rd & 32'h3400, 32'h0000_2000)
    apb(1'b1, CTRL_OFF, 32'h2003);
    `CK({ren, ten}, 2'h3)
    pulse_soft();
    `CK({ren, ten}, 2'h0)
    apb(1'b0, 12'h00C, 32'h0);
    `CK({er, rd}, 33'h1_0000_0000)
    complete_run();
  end
endmodule
`default_nettype wire
